// File: eeh_pkg.sv
// shared constants and types for the serial eeprom host controller
package eeh_pkg;
	// ====================================================================
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int SCL_HZ = 400_000;
	// quarter of a bus clock; rounded up so the bus never runs too fast
	localparam int QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
	localparam int PROG_TIME_US = 3000;
	localparam int PROG_CYC = PROG_TIME_US * (CLK_HZ / 1_000_000);
	// ====================================================================
	// address byte and array layout
	localparam logic [3:0] DEV_CODE = 4'ha;
	localparam logic DIR_READ = 1'b1;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] RECOV_BITS = 4'h9;
	localparam int PAGE_BYTES = 16;
	// ====================================================================
	// types
	typedef enum logic [1:0] {
		OP_WRITE,
		OP_READ_CUR,
		OP_READ_RAND,
		OP_RECOVER
	} eeh_op_e;
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RECOV,
		ST_START,
		ST_ADDR,
		ST_WORD,
		ST_DATA,
		ST_RSTART,
		ST_RADDR,
		ST_READ,
		ST_STOP
	} eeh_state_e;
	typedef struct packed {
		eeh_op_e op;
		logic [2:0] chip_select_straps;
		logic [7:0] word_addr;
		logic [7:0] count_m1;
	} eeh_cmd_s;
	typedef struct packed {
		logic nack;
		logic timeout;
	} eeh_status_s;
endpackage

// File: eeh_host.sv
// host controller driving a two-wire serial eeprom through its pins
// Summary of operation
// - data line changes only while clock is low, except start and stop.
// - start is data falling while clock high; issued before every command; the recovery command gives its nine clocks first.
// - stop is data rising while clock high; ends the transaction.
// - recovery gives nine clocks with data high, then a start.
// - address byte is 1010, three strap bits, then direction bit.
// - byte write is address, word address, data, then stop starting programming.
// - page write continues data bytes up to 16, ended by stop; the host sends count_m1 plus one bytes, up to 256, with no limit at 16.
// - host polls with start and address until the device acknowledges; the code gives up after POLL_CYC cycles and flags timeout.
// - current read returns one byte, host withholds acknowledge, then stops; the code reads count_m1 plus one bytes.
// - random read is dummy write of word address, repeated start, read.
// - host acknowledges to continue a sequential read; no acknowledge ends it.
`timescale 1ns/1ps
module eeh_host #(
	parameter int POLL_CYC = eeh_pkg::PROG_CYC,
	parameter int QTR_CYC = eeh_pkg::QTR_CYC
) (
	input wire logic ref_clk, // system clock
	input wire logic reset_n, // asynchronous reset
	input wire logic cmd_valid, // command offered
	output logic cmd_ready, // command taken when both high
	input eeh_pkg::eeh_cmd_s cmd, // command fields
	input wire logic wr_valid, // write byte offered
	output logic wr_ready, // write byte taken when both high
	input wire logic [7:0] wr_data, // write byte
	output logic rd_valid, // read byte pulse
	output logic [7:0] rd_data, // read byte
	output logic done, // command finished pulse
	output eeh_pkg::eeh_status_s status, // result of last command
	input wire logic wp_enable, // request write protection
	output logic wp_pin, // write-protect pin
	output logic scl_o, // bus clock pin
	input wire logic sda_i, // data pin level
	output logic sda_o, // data pin drive value
	output logic sda_oe // data pin pulled low when high
);
	localparam int DIV_W = $clog2(QTR_CYC + 1);
	localparam int PT_W = $clog2(POLL_CYC + 1);

	function automatic logic [7:0] addr_byte(input logic [2:0] straps, input logic dir);
		addr_byte = {eeh_pkg::DEV_CODE, straps, dir};
	endfunction

	// ====================================================================
	// data pin synchroniser
	logic sda_s1_ff, sda_s2_ff, sda_s3_ff, sda_seen_ff;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
			sda_s3_ff <= 1'b1;
			sda_seen_ff <= 1'b1;
		end else begin
			sda_s1_ff <= sda_i;
			sda_s2_ff <= sda_s1_ff;
			sda_s3_ff <= sda_s2_ff;
			if (sda_s2_ff == sda_s3_ff) begin
				sda_seen_ff <= sda_s3_ff;
			end
		end
	end

	// ====================================================================
	// sequencer state
	eeh_pkg::eeh_state_e st_ff;
	eeh_pkg::eeh_cmd_s cmd_ff;
	logic [DIV_W-1:0] div_ff;
	logic [1:0] q_ff;
	logic [3:0] bit_ff;
	logic [7:0] tx_ff, rx_ff, cnt_ff;
	logic have_ff, poll_ff, need_poll_ff, acked_ff, err_ff;
	logic [PT_W-1:0] poll_cnt_ff;
	logic scl_ff, sda_ff, rd_valid_ff, done_ff, wp_ff;
	logic [7:0] rd_data_ff;
	eeh_pkg::eeh_status_s status_ff;

	wire tick = (div_ff == DIV_W'(QTR_CYC - 1));
	wire busy = (st_ff != eeh_pkg::ST_IDLE);
	wire stall = (st_ff == eeh_pkg::ST_DATA) && !have_ff;
	wire advance = tick && busy && !stall;
	wire end_q = advance && (q_ff == 2'd3);
	wire byte_end = end_q && (bit_ff == eeh_pkg::ACK_BIT);
	wire is_edge = (st_ff == eeh_pkg::ST_START) || (st_ff == eeh_pkg::ST_RSTART)
		|| (st_ff == eeh_pkg::ST_STOP);
	wire is_rx = (st_ff == eeh_pkg::ST_READ);
	wire ack_seen = !sda_seen_ff;
	wire last_rd = (cnt_ff == 8'h00);
	wire poll_out = (poll_cnt_ff >= PT_W'(POLL_CYC - 1));
	wire accept = cmd_valid && cmd_ready;
	wire wr_take = wr_valid && wr_ready;

	// ====================================================================
	// pin levels per quarter
	logic nxt_scl, nxt_sda, bit_val;
	always_comb begin
		if (is_rx) begin
			// ack all but the last read byte
			bit_val = (bit_ff == eeh_pkg::ACK_BIT) ? last_rd : 1'b1;
		end else if (st_ff == eeh_pkg::ST_RECOV || bit_ff == eeh_pkg::ACK_BIT) begin
			bit_val = 1'b1;
		end else begin
			bit_val = tx_ff[7];
		end
		if (!busy) begin
			nxt_scl = 1'b1;
			nxt_sda = 1'b1;
		end else if (is_edge) begin
			// clock low for q0..q1, high for q2..q3; the data edge lands in q3
			nxt_scl = q_ff[1];
			if (q_ff == 2'd0) begin
				nxt_sda = sda_ff;
			end else if (st_ff == eeh_pkg::ST_STOP) begin
				nxt_sda = (q_ff == 2'd3);
			end else begin
				nxt_sda = (q_ff != 2'd3);
			end
		end else begin
			// data moves one quarter after the clock falls
			nxt_scl = q_ff[1];
			nxt_sda = (q_ff == 2'd0) ? sda_ff : bit_val;
		end
	end

	// ====================================================================
	// bus clock divider and pins
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_ff <= '0;
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
			wp_ff <= 1'b0;
		end else begin
			div_ff <= tick ? '0 : div_ff + 1'b1;
			scl_ff <= nxt_scl;
			sda_ff <= nxt_sda;
			wp_ff <= wp_enable;
		end
	end

	// ====================================================================
	// command sequencer
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= eeh_pkg::ST_IDLE;
			cmd_ff <= '0;
			q_ff <= 2'd0;
			bit_ff <= 4'h0;
			tx_ff <= 8'h00;
			rx_ff <= 8'h00;
			cnt_ff <= 8'h00;
			have_ff <= 1'b0;
			poll_ff <= 1'b0;
			need_poll_ff <= 1'b0;
			acked_ff <= 1'b0;
			err_ff <= 1'b0;
			poll_cnt_ff <= '0;
			rd_valid_ff <= 1'b0;
			rd_data_ff <= 8'h00;
			done_ff <= 1'b0;
			status_ff <= '0;
		end else begin
			rd_valid_ff <= 1'b0;
			done_ff <= 1'b0;
			poll_cnt_ff <= (poll_ff && !poll_out) ? poll_cnt_ff + 1'b1 : poll_cnt_ff;
			if (accept) begin
				cmd_ff <= cmd;
				cnt_ff <= cmd.count_m1;
				err_ff <= 1'b0;
				acked_ff <= 1'b0;
				poll_ff <= 1'b0;
				need_poll_ff <= 1'b0;
				q_ff <= 2'd0;
				bit_ff <= 4'h0;
				st_ff <= (cmd.op == eeh_pkg::OP_RECOVER) ? eeh_pkg::ST_RECOV
					: eeh_pkg::ST_START;
			end
			if (wr_take) begin
				tx_ff <= wr_data;
				have_ff <= 1'b1;
			end
			if (advance) begin
				q_ff <= q_ff + 2'd1;
			end
			if (end_q && !is_edge && bit_ff != eeh_pkg::ACK_BIT) begin
				bit_ff <= bit_ff + 4'h1;
				tx_ff <= {tx_ff[6:0], 1'b0};
				rx_ff <= {rx_ff[6:0], sda_seen_ff};
				if (is_rx && bit_ff == 4'h7) begin
					rd_data_ff <= {rx_ff[6:0], sda_seen_ff};
					rd_valid_ff <= 1'b1;
				end
			end
			if (end_q && is_edge) begin
				bit_ff <= 4'h0;
				case (st_ff)
					eeh_pkg::ST_START: begin
						if (cmd_ff.op == eeh_pkg::OP_RECOVER) begin
							st_ff <= eeh_pkg::ST_STOP;
						end else begin
							st_ff <= eeh_pkg::ST_ADDR;
							tx_ff <= addr_byte(cmd_ff.chip_select_straps,
								(cmd_ff.op == eeh_pkg::OP_READ_CUR) && !poll_ff);
						end
					end
					eeh_pkg::ST_RSTART: begin
						st_ff <= eeh_pkg::ST_RADDR;
						tx_ff <= addr_byte(cmd_ff.chip_select_straps, eeh_pkg::DIR_READ);
					end
					default: begin
						// end of stop: start polling after a write, retry, or finish
						if (need_poll_ff) begin
							need_poll_ff <= 1'b0;
							poll_ff <= 1'b1;
							poll_cnt_ff <= '0;
							st_ff <= eeh_pkg::ST_START;
						end else if (poll_ff && !acked_ff && !poll_out) begin
							st_ff <= eeh_pkg::ST_START;
						end else begin
							st_ff <= eeh_pkg::ST_IDLE;
							poll_ff <= 1'b0;
							done_ff <= 1'b1;
							status_ff <= '{nack: err_ff, timeout: poll_ff && !acked_ff};
						end
					end
				endcase
			end
			if (byte_end) begin
				bit_ff <= 4'h0;
				case (st_ff)
					eeh_pkg::ST_RECOV: begin
						st_ff <= eeh_pkg::ST_START;
					end
					eeh_pkg::ST_ADDR: begin
						if (poll_ff) begin
							acked_ff <= ack_seen;
							st_ff <= eeh_pkg::ST_STOP;
						end else if (!ack_seen) begin
							err_ff <= 1'b1;
							st_ff <= eeh_pkg::ST_STOP;
						end else if (cmd_ff.op == eeh_pkg::OP_READ_CUR) begin
							st_ff <= eeh_pkg::ST_READ;
						end else begin
							st_ff <= eeh_pkg::ST_WORD;
							tx_ff <= cmd_ff.word_addr;
						end
					end
					eeh_pkg::ST_WORD: begin
						if (!ack_seen) begin
							err_ff <= 1'b1;
							st_ff <= eeh_pkg::ST_STOP;
						end else if (cmd_ff.op == eeh_pkg::OP_WRITE) begin
							st_ff <= eeh_pkg::ST_DATA;
							have_ff <= 1'b0;
						end else begin
							st_ff <= eeh_pkg::ST_RSTART;
						end
					end
					eeh_pkg::ST_DATA: begin
						have_ff <= 1'b0;
						cnt_ff <= cnt_ff - 8'h01;
						if (!ack_seen) begin
							err_ff <= 1'b1;
							st_ff <= eeh_pkg::ST_STOP;
						end else if (last_rd) begin
							need_poll_ff <= 1'b1;
							st_ff <= eeh_pkg::ST_STOP;
						end
					end
					eeh_pkg::ST_RADDR: begin
						err_ff <= !ack_seen;
						st_ff <= ack_seen ? eeh_pkg::ST_READ : eeh_pkg::ST_STOP;
					end
					default: begin
						cnt_ff <= cnt_ff - 8'h01;
						if (last_rd) begin
							st_ff <= eeh_pkg::ST_STOP;
						end
					end
				endcase
			end
		end
	end

	assign cmd_ready = !busy;
	assign wr_ready = stall;
	assign rd_valid = rd_valid_ff;
	assign rd_data = rd_data_ff;
	assign done = done_ff;
	assign status = status_ff;
	assign wp_pin = wp_ff;
	assign scl_o = scl_ff;
	assign sda_o = 1'b0;
	assign sda_oe = !sda_ff;

	// ====================================================================
	// checks
	logic [3:0] rec_rises_ff;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rec_rises_ff <= 4'h0;
		end else if (st_ff != eeh_pkg::ST_RECOV) begin
			rec_rises_ff <= 4'h0;
		end else if (!scl_ff && nxt_scl) begin
			rec_rises_ff <= rec_rises_ff + 4'h1;
		end
	end

	AST_SDA_STABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(scl_ff && $past(scl_ff) && $changed(sda_ff)) |-> $past(is_edge))
		else $error("data changed while clock high outside start or stop");
	AST_START_EDGE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(scl_ff && $past(scl_ff) && $fell(sda_ff)) |->
		($past(st_ff) == eeh_pkg::ST_START || $past(st_ff) == eeh_pkg::ST_RSTART))
		else $error("data fell with clock high outside a start");
	AST_STOP_EDGE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(scl_ff && $past(scl_ff) && $rose(sda_ff)) |-> ($past(st_ff) == eeh_pkg::ST_STOP))
		else $error("data rose with clock high outside a stop");
	AST_CHANGE_AFTER_FALL: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(scl_ff) |-> $stable(sda_ff) ##1 !scl_ff)
		else $error("data moved on the clock falling edge");
	AST_READ_ACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(is_rx && bit_ff == eeh_pkg::ACK_BIT && q_ff == 2'd2 && !last_rd) |-> ##1 !sda_ff)
		else $error("no acknowledge driven after a read byte");
	AST_LAST_NOACK: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(is_rx && bit_ff == eeh_pkg::ACK_BIT && q_ff == 2'd2 && last_rd) |-> ##1 sda_ff)
		else $error("last read byte was acknowledged");
	AST_ADDR_PREFIX: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(st_ff == eeh_pkg::ST_ADDR && $past(st_ff) != eeh_pkg::ST_ADDR) |->
		(tx_ff[7:4] == eeh_pkg::DEV_CODE && tx_ff[3:1] == cmd_ff.chip_select_straps))
		else $error("address byte prefix wrong");
	AST_RECOV_NINE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		($past(st_ff) == eeh_pkg::ST_RECOV && st_ff == eeh_pkg::ST_START) |->
		(rec_rises_ff == eeh_pkg::RECOV_BITS))
		else $error("recovery did not give nine clocks");
	AST_RANDOM_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(st_ff == eeh_pkg::ST_RADDR && $past(st_ff) != eeh_pkg::ST_RADDR) |->
		($past(st_ff) == eeh_pkg::ST_RSTART && tx_ff[0] == eeh_pkg::DIR_READ))
		else $error("random read address byte not after repeated start");
endmodule

// File: eeh_mem_model.sv
// behavioural model of the serial eeprom at the far side of the host
`timescale 1ns/1ps
module eeh_mem_model #(
	parameter logic [2:0] STRAPS = 3'h5,
	parameter int PROG_NS = 10000
) (
	input wire logic scl, // bus clock from the host
	input wire logic sda, // resolved data line
	input wire logic wp, // write-protect pin
	output logic sda_oe // pulls the data line low when high
);
	localparam int M_IDLE = 0;
	localparam int M_ADDR = 1;
	localparam int M_WORD = 2;
	localparam int M_WDAT = 3;
	localparam int M_READ = 4;
	logic [7:0] mem [256];
	logic [7:0] pend [int];
	logic [7:0] sh = 8'h00;
	logic [7:0] ob = 8'h00;
	logic [7:0] ptr = 8'h00;
	int mode = M_IDLE;
	int nxt = M_IDLE;
	int bitn = 0;
	logic busy = 1'b0;
	logic mack = 1'b0;
	initial begin
		sda_oe = 1'b0;
		foreach (mem[i]) mem[i] = 8'hff;
	end
	// ====================================================================
	// start and stop
	always @(negedge sda) begin
		if (scl === 1'b1 && !busy) begin
			mode = M_ADDR;
			bitn = -1;
			pend.delete();
		end
	end
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			// programming is whole-stop only; an aborted write never lands
			if (!busy && pend.num() > 0 && !wp) begin
				foreach (pend[a]) mem[a] = pend[a];
				busy = 1'b1;
				fork
					#(PROG_NS) busy = 1'b0;
				join_none
			end
			pend.delete();
			mode = M_IDLE;
			sda_oe = 1'b0;
		end
	end
	// ====================================================================
	// bits
	always @(posedge scl) begin
		sh = {sh[6:0], sda};
		mack = (sda == 1'b0);
	end
	always @(negedge scl) begin
		if (mode != M_IDLE) begin
			bitn = bitn + 1;
			sda_oe = 1'b0;
			if (bitn == 8 && mode != M_READ) begin
				sda_oe = 1'b1;
				nxt = M_WDAT;
				if (mode == M_ADDR) begin
					sda_oe = (sh[7:1] == {4'ha, STRAPS});
					nxt = sh[0] ? M_READ : M_WORD;
					if (!sda_oe) mode = M_IDLE;
				end else if (mode == M_WORD) begin
					ptr = sh;
				end else begin
					pend[int'(ptr)] = sh;
					ptr[3:0] = ptr[3:0] + 4'h1;
				end
			end else if (bitn == 9) begin
				bitn = 0;
				if (nxt == M_READ && (mode != M_READ || mack)) begin
					ob = mem[ptr];
					ptr = ptr + 8'h01;
					mode = M_READ;
				end else begin
					mode = (nxt == M_READ) ? M_IDLE : nxt;
				end
			end
			if (mode == M_READ && bitn < 8) sda_oe = !ob[7 - bitn];
		end
	end
endmodule

// File: tb_top.sv
// self-checking bench for the serial eeprom host controller
`timescale 1ns/1ps
module tb_top;
	typedef struct {
		eeh_pkg::eeh_op_e op;
		logic [2:0] st;
		logic [7:0] wa;
		logic [7:0] n;
		logic wp;
		logic nk;
	} eeh_row_s;
	localparam eeh_pkg::eeh_op_e W = eeh_pkg::OP_WRITE;
	localparam eeh_pkg::eeh_op_e RC = eeh_pkg::OP_READ_CUR;
	localparam eeh_pkg::eeh_op_e RR = eeh_pkg::OP_READ_RAND;
	localparam eeh_pkg::eeh_op_e RV = eeh_pkg::OP_RECOVER;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic wr_valid = 1'b0;
	logic wp_enable = 1'b0;
	logic [7:0] wr_data = 8'h00;
	eeh_pkg::eeh_cmd_s cmd = '0;
	logic cmd_ready, wr_ready, rd_valid, done, wp_pin, scl_o, sda_o, sda_oe, dev_oe, sda_line;
	logic [7:0] rd_data;
	eeh_pkg::eeh_status_s status;
	logic [7:0] shadow [256];
	logic [7:0] got [32];
	logic [7:0] ptr = 8'h00;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	int wi, ri;
	eeh_row_s rows [16] = '{
		'{W, 3'h5, 8'h10, 8'h01, 1'b0, 1'b0}, '{RR, 3'h5, 8'h10, 8'h01, 1'b0, 1'b0},
		'{W, 3'h5, 8'h1e, 8'h03, 1'b0, 1'b0}, '{RR, 3'h5, 8'h10, 8'h0f, 1'b0, 1'b0},
		'{RC, 3'h5, 8'h00, 8'h00, 1'b0, 1'b0}, '{W, 3'h5, 8'h30, 8'h10, 1'b0, 1'b0},
		'{RR, 3'h5, 8'h30, 8'h0f, 1'b0, 1'b0}, '{W, 3'h5, 8'h40, 8'h00, 1'b1, 1'b0},
		'{RR, 3'h5, 8'h40, 8'h00, 1'b0, 1'b0}, '{RC, 3'h5, 8'h00, 8'h01, 1'b0, 1'b0},
		'{W, 3'h2, 8'h50, 8'h00, 1'b0, 1'b1}, '{RR, 3'h2, 8'h50, 8'h00, 1'b0, 1'b1},
		'{W, 3'h5, 8'hf0, 8'h0f, 1'b0, 1'b0}, '{RR, 3'h5, 8'hfe, 8'h03, 1'b0, 1'b0},
		'{RV, 3'h5, 8'h00, 8'h00, 1'b0, 1'b0}, '{RC, 3'h5, 8'h00, 8'h00, 1'b0, 1'b0}};
	// pull-up unless either end pulls low
	assign sda_line = !(sda_oe || dev_oe);
	eeh_host #(.POLL_CYC(2000), .QTR_CYC(4)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid),
		.wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
		.done(done), .status(status), .wp_enable(wp_enable), .wp_pin(wp_pin), .scl_o(scl_o),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
	eeh_mem_model #(.STRAPS(3'h5), .PROG_NS(10000)) dev (.scl(scl_o), .sda(sda_line),
		.wp(wp_pin), .sda_oe(dev_oe));
	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	// ====================================================================
	// helpers
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] dbyte(input logic [7:0] wa, input int i);
		return (wa + 8'(i) * 8'h1d) ^ 8'ha5;
	endfunction
	task automatic run(input eeh_row_s r);
		int k;
		@(negedge ref_clk);
		wp_enable = r.wp;
		cmd = '{op: r.op, chip_select_straps: r.st, word_addr: r.wa, count_m1: r.n};
		cmd_valid = 1'b1;
		do @(posedge ref_clk); while (cmd_ready !== 1'b1);
		wi = 0;
		ri = 0;
		for (k = 0; k < 40000 && done !== 1'b1; k++) begin
			@(negedge ref_clk);
			cmd_valid = 1'b0;
			wr_valid = (r.op == W);
			wr_data = dbyte(r.wa, wi);
			if (wr_ready === 1'b1) wi++;
			if (rd_valid === 1'b1 && ri < 32) begin
				got[ri] = rd_data;
				ri++;
			end
		end
		wr_valid = 1'b0;
	endtask
	task automatic expect_row(input eeh_row_s r);
		int i;
		logic [7:0] a;
		chk(status.nack, r.nk);
		chk(status.timeout, 8'h00);
		if (r.nk || r.op == RV) return;
		a = (r.op == RC) ? ptr : r.wa;
		for (i = 0; i <= r.n; i++) begin
			if (r.op != W) chk(got[i], shadow[a]);
			else if (!r.wp) shadow[a] = dbyte(r.wa, i);
			a = (r.op == W) ? {a[7:4], a[3:0] + 4'h1} : a + 8'h01;
		end
		ptr = a;
		if (r.op == W) chk(8'(wi), r.n + 8'h01);
		else chk(8'(ri), r.n + 8'h01);
	endtask
	// ====================================================================
	// sequence
	initial begin
		repeat (12) @(negedge ref_clk);
		chk(cmd_ready, 8'h01);
		chk(scl_o, 8'h01);
		chk(sda_oe, 8'h00);
		chk(sda_o, 8'h00);
		chk(wr_ready, 8'h00);
		chk(done, 8'h00);
		chk(rd_valid, 8'h00);
		reset_n = 1'b1;
		foreach (shadow[i]) shadow[i] = 8'hff;
		foreach (rows[i]) begin
			run(rows[i]);
			expect_row(rows[i]);
		end
		wp_enable = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(wp_pin, 8'h01);
		// reset in mid-read can leave the device holding data low
		cmd = '{op: RR, chip_select_straps: 3'h5, word_addr: 8'h10, count_m1: 8'h03};
		cmd_valid = 1'b1;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		repeat (500) @(negedge ref_clk);
		reset_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(cmd_ready, 8'h01);
		chk(scl_o, 8'h01);
		chk(sda_oe, 8'h00);
		reset_n = 1'b1;
		run(rows[14]);
		expect_row(rows[14]);
		run(rows[1]);
		expect_row(rows[1]);
		complete_run();
	end
endmodule
